// file: ewp_pkg.sv
// constants for the write-protected eeprom serial slave
package ewp_pkg;
  localparam int ADDR_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam logic [3:0] DEV_MEM = 4'ha;
  localparam logic [3:0] DEV_PROT = 4'h6;
  localparam logic [7:0] PROT_LIMIT = 8'h80;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic PROT_RESET = 1'b0;

  typedef enum logic [3:0] {
    EWP_IDLE = 4'h0,
    EWP_DEV = 4'h1,
    EWP_ACK_DEV = 4'h3,
    EWP_WADDR = 4'h2,
    EWP_ACK_WADDR = 4'h6,
    EWP_WDATA = 4'h7,
    EWP_ACK_WDATA = 4'h5,
    EWP_RD = 4'hb,
    EWP_RD_ACK = 4'h9
  } ewp_state_e;
endpackage : ewp_pkg

// file: ewp_line_if.sv
// synchronised serial line levels and events between the slave modules
`timescale 1ns/1ns
interface ewp_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, output sda, output scl_rise, output scl_fall, output start, output stop);
  modport dst (input scl, input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface : ewp_line_if

// file: ewp_line_sync.sv
// two-flop synchroniser and edge, start and stop detection for the serial lines
`timescale 1ns/1ns
module ewp_line_sync
  import ewp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  ewp_line_if.src line
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic scl_m;
    logic sda_m;
    logic scl_q;
    logic sda_q;
    logic scl_p;
    logic sda_p;
  } ewp_sync_s;

  ewp_sync_s s;
  ewp_sync_s next_s;

  always_comb begin
    next_s = s;
    next_s.scl_m = scl_i;
    next_s.sda_m = sda_i;
    next_s.scl_q = s.scl_m;
    next_s.sda_q = s.sda_m;
    next_s.scl_p = s.scl_q;
    next_s.sda_p = s.sda_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '{default: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // events
  // ****************************************
  assign line.scl = s.scl_q;
  assign line.sda = s.sda_q;
  assign line.scl_rise = s.scl_q & ~s.scl_p;
  assign line.scl_fall = ~s.scl_q & s.scl_p;
  assign line.start = s.scl_q & s.scl_p & s.sda_p & ~s.sda_q;
  assign line.stop = s.scl_q & s.scl_p & ~s.sda_p & s.sda_q;
endmodule : ewp_line_sync

// file: ewp_slave.sv
// serial eeprom slave with protect register, protect pin and read operations
`timescale 1ns/1ns
module ewp_slave
  import ewp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic wp_i,
  input wire logic [2:0] addr_pins,
  output logic protect_state
);
  // ****************************************
  // line front end
  // ****************************************
  ewp_line_if line ();

  ewp_line_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line(line)
  );

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ewp_state_e st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] paddr;
    logic [7:0] pdata;
    logic sel_prot;
    logic rd;
    logic mack;
    logic pend_mem;
    logic pend_prot;
    logic drv;
    logic lvl;
    logic wp_m;
    logic wp_q;
    logic [2:0] a_m;
    logic [2:0] a_q;
  } ewp_slave_s;

  ewp_slave_s s;
  ewp_slave_s next_s;

  logic [7:0] mem [MEM_DEPTH];
  logic protect = PROT_RESET;
  logic [7:0] rd_byte;
  logic mem_we;
  logic prot_we;
  logic blocked;
  logic hit_mem;
  logic hit_prot;

  assign rd_byte = mem[s.cnt];

  always_comb begin
    next_s = s;
    next_s.wp_m = wp_i;
    next_s.wp_q = s.wp_m;
    next_s.a_m = addr_pins;
    next_s.a_q = s.a_m;
    next_s.lvl = 1'b0;
    mem_we = 1'b0;
    prot_we = 1'b0;
    hit_mem = (s.sh[7:4] == DEV_MEM) && (s.sh[3:1] == s.a_q);
    hit_prot = (s.sh[7:4] == DEV_PROT) && (s.sh[3:1] == s.a_q) && !s.sh[0] && !protect;
    blocked = s.wp_q || (s.sel_prot && protect) || (!s.sel_prot && protect && (s.wa < PROT_LIMIT));
    if (line.start) begin
      next_s.st = EWP_DEV;
      next_s.bits = '0;
      next_s.drv = 1'b0;
      next_s.pend_mem = 1'b0;
      next_s.pend_prot = 1'b0;
    end else if (line.stop) begin
      next_s.st = EWP_IDLE;
      next_s.drv = 1'b0;
      next_s.pend_mem = 1'b0;
      next_s.pend_prot = 1'b0;
      mem_we = s.pend_mem && !s.wp_q;
      prot_we = s.pend_prot && !s.wp_q;
    end else begin
      unique case (s.st)
        EWP_IDLE: begin
          next_s.drv = 1'b0;
        end
        EWP_DEV, EWP_WADDR, EWP_WDATA: begin
          if (line.scl_rise) begin
            next_s.sh = {s.sh[6:0], line.sda};
            next_s.bits = s.bits + 4'h1;
          end else if (line.scl_fall && (s.bits == BITS_PER_BYTE)) begin
            next_s.bits = '0;
            if (s.st == EWP_DEV) begin
              if (hit_mem || hit_prot) begin
                next_s.drv = 1'b1;
                next_s.sel_prot = hit_prot;
                next_s.rd = s.sh[0];
                next_s.st = EWP_ACK_DEV;
              end else begin
                next_s.st = EWP_IDLE;
              end
            end else if (s.st == EWP_WADDR) begin
              next_s.drv = 1'b1;
              next_s.st = EWP_ACK_WADDR;
              if (!s.sel_prot) begin
                next_s.wa = s.sh;
                next_s.cnt = s.sh;
              end
            end else if (!blocked) begin
              next_s.drv = 1'b1;
              next_s.st = EWP_ACK_WDATA;
              next_s.pend_mem = !s.sel_prot;
              next_s.pend_prot = s.sel_prot;
              next_s.paddr = s.wa;
              next_s.pdata = s.sh;
              if (!s.sel_prot) begin
                next_s.wa = s.wa + 8'h01;
                next_s.cnt = s.wa + 8'h01;
              end
            end else begin
              next_s.st = EWP_IDLE;
            end
          end
        end
        EWP_ACK_DEV: begin
          if (line.scl_fall) begin
            next_s.bits = '0;
            if (s.rd) begin
              next_s.tx = rd_byte;
              next_s.drv = ~rd_byte[7];
              next_s.st = EWP_RD;
            end else begin
              next_s.drv = 1'b0;
              next_s.st = EWP_WADDR;
            end
          end
        end
        EWP_ACK_WADDR, EWP_ACK_WDATA: begin
          if (line.scl_fall) begin
            next_s.drv = 1'b0;
            next_s.st = EWP_WDATA;
          end
        end
        EWP_RD: begin
          if (line.scl_rise) begin
            next_s.bits = s.bits + 4'h1;
          end else if (line.scl_fall) begin
            if (s.bits == BITS_PER_BYTE) begin
              next_s.drv = 1'b0;
              next_s.st = EWP_RD_ACK;
              next_s.cnt = s.cnt + 8'h01;
            end else begin
              next_s.tx = {s.tx[6:0], 1'b0};
              next_s.drv = ~s.tx[6];
            end
          end
        end
        EWP_RD_ACK: begin
          if (line.scl_rise) begin
            next_s.mack = ~line.sda;
          end else if (line.scl_fall) begin
            next_s.bits = '0;
            if (s.mack) begin
              next_s.tx = rd_byte;
              next_s.drv = ~rd_byte[7];
              next_s.st = EWP_RD;
            end else begin
              next_s.drv = 1'b0;
              next_s.st = EWP_IDLE;
            end
          end
        end
        default: begin
          next_s.st = EWP_IDLE;
          next_s.drv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.st <= EWP_IDLE;
      s.wp_m <= 1'b1;
      s.wp_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // array and protect storage
  // ****************************************
  // no reset: models nonvolatile cells
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[s.paddr] <= s.pdata;
    end
    if (prot_we) begin
      protect <= 1'b1;
    end
    protect_state <= protect;
  end

  assign sda_o = s.lvl;
  assign sda_oe = s.drv;
endmodule : ewp_slave

// file: ewp_slave_properties.sv
// port assertions for the eeprom serial slave
`timescale 1ns/1ns
module ewp_slave_properties(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic wp_i,
  input wire logic protect_state
);
  logic psda = 1'h1;
  logic [7:0] since = 8'hff;
  logic [7:0] run = 8'h00;
  // cycles since a stop, length of a drive
  always_ff @(posedge core_clk) begin
    psda <= sda_i;
    since <= (scl_i && sda_i && !psda) ? 8'h00 : since + {7'h0, since != 8'hff};
    run <= sda_oe ? run + 8'h01 : 8'h00;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_open_drain: assert property (!sda_o) else $error("sda driven high");
  a_prot_keeps: assert property (!$fell(protect_state)) else $error("protect cleared");
  a_wp_hold: assert property (wp_i && $past(wp_i, 6) |=> $stable(protect_state)) else $error("pin bypassed");
  a_prot_at_stop: assert property ($rose(protect_state) |-> since < 8'h10) else $error("set off stop");
  a_oe_scl_high: assert property ($rose(scl_i) |=> $stable(sda_oe) [*3]) else $error("drive moved");
  a_oe_run: assert property (run < 8'h50) else $error("drive too long");
  a_start_quiet: assert property (scl_i && $fell(sda_i) |-> !sda_oe [*8]) else $error("drive at start");
  a_stop_quiet: assert property (scl_i && $rose(sda_i) |-> !sda_oe [*8]) else $error("drive at stop");
  c_prot: cover property ($rose(protect_state));
  c_ack: cover property (run == 8'h08);
  c_stop: cover property (since == 8'h00);
endmodule : ewp_slave_properties
bind ewp_slave ewp_slave_properties i_props(.core_clk, .rst, .scl_i, .sda_i, .sda_o, .sda_oe, .wp_i, .protect_state);

// file: ewp_master_model.sv
// two-wire bus master model for the eeprom slave
`timescale 1ns/1ns
module ewp_master_model(
  input wire logic core_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic sda_m = 1'h1;
  // pulled-up line: released reads high
  assign sda = sda_m & ~sda_oe;
  initial scl = 1'h1;
  // quarter of an 80 ns bus period
  task automatic step(input logic c, input logic d);
    scl = c;
    sda_m = d;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : step
  task automatic wave(input logic [5:0] c, input logic [5:0] d);
    for (int i = 5; i >= 0; i--) begin
      step(c[i], d[i]);
    end
  endtask : wave
  task automatic start();
    wave(6'h0f, {sda_m, 5'h1c});
  endtask : start
  task automatic stop();
    wave(6'h0f, {sda_m, 5'h03});
  endtask : stop
  task automatic bit_io(input logic b, output logic v);
    step(1'h0, sda_m);
    step(1'h0, b);
    step(1'h1, b);
    step(1'h1, b);
    v = sda;
  endtask : bit_io
  // m_ack low acknowledges a byte sent by the slave
  task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] v, output logic s_ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], v[i]);
    end
    bit_io(m_ack, s_ack);
  endtask : xfer
endmodule : ewp_master_model

// file: ewp_slave_test.sv
// self-checking bench for the eeprom serial slave
`timescale 1ns/1ns
module ewp_slave_test;
  import ewp_pkg::*;
  localparam logic [2:0] PINS = 3'h5;
  logic core_clk;
  logic rst;
  logic wp_i;
  logic scl;
  logic sda;
  logic sda_oe;
  logic prot;
  logic [7:0] r;
  logic [2:0] s;
  int err_count = 0;
  int checks_done = 0;
  ewp_slave i_dut(.core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .wp_i(wp_i), .addr_pins(PINS), .protect_state(prot));
  ewp_master_model i_m(.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse_rst();
    rst = 1'h1;
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'h0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : pulse_rst
  task automatic wr(input logic [3:0] dev, input logic [7:0] a, input logic [7:0] d, input logic [2:0] acks);
    i_m.start();
    i_m.xfer({dev, PINS, 1'h0}, 1'h1, r, s[2]);
    i_m.xfer(a, 1'h1, r, s[1]);
    i_m.xfer(d, 1'h1, r, s[0]);
    i_m.stop();
    repeat (8) @(posedge core_clk);
    #1;
    chk({5'h0, ~s}, {5'h0, acks});
  endtask : wr
  task automatic rd_at(input logic [7:0] a);
    i_m.start();
    i_m.xfer({DEV_MEM, PINS, 1'h0}, 1'h1, r, s[1]);
    i_m.xfer(a, 1'h1, r, s[0]);
    chk({6'h0, s[1:0]}, 8'h00);
  endtask : rd_at
  task automatic rd(input logic [7:0] e0, input logic [7:0] e1, input logic two);
    i_m.start();
    i_m.xfer({DEV_MEM, PINS, 1'h1}, 1'h1, r, s[0]);
    chk({7'h0, s[0]}, 8'h00);
    i_m.xfer(8'hff, ~two, r, s[0]);
    chk(r, e0);
    if (two) begin
      i_m.xfer(8'hff, 1'h1, r, s[0]);
      chk(r, e1);
    end
    i_m.stop();
  endtask : rd
  task automatic t_read();
    wr(DEV_MEM, 8'h02, 8'h5a, 3'h7);
    wr(DEV_MEM, 8'hff, 8'hc3, 3'h7);
    wr(DEV_MEM, 8'h01, 8'h96, 3'h7);
    wr(DEV_MEM, 8'h00, 8'h3c, 3'h7);
    rd(8'h96, 8'h5a, 1'h1);
    rd_at(8'hff);
    rd(8'hc3, 8'h3c, 1'h1);
    rd(8'h96, 8'h00, 1'h0);
  endtask : t_read
  task automatic t_wp();
    wp_i = 1'h1;
    wr(DEV_MEM, 8'h02, 8'h11, 3'h6);
    wr(DEV_PROT, 8'h00, 8'h00, 3'h6);
    chk({7'h0, prot}, 8'h00);
    wp_i = 1'h0;
    rd_at(8'h02);
    rd(8'h5a, 8'h00, 1'h0);
  endtask : t_wp
  task automatic t_prot();
    wr(4'h7, 8'h00, 8'h00, 3'h0);
    wr(DEV_PROT, 8'h02, 8'haa, 3'h7);
    chk({7'h0, prot}, 8'h01);
    wr(DEV_PROT, 8'h00, 8'h00, 3'h0);
    wr(DEV_MEM, 8'h7f, 8'h22, 3'h6);
    wr(DEV_MEM, 8'h01, 8'h22, 3'h6);
    wr(DEV_MEM, 8'h80, 8'h44, 3'h7);
    rd_at(8'h80);
    rd(8'h44, 8'h00, 1'h0);
    rd_at(8'h01);
    rd(8'h96, 8'h5a, 1'h1);
    pulse_rst();
    chk({7'h0, prot}, 8'h01);
  endtask : t_prot
  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    wp_i = 1'h0;
    pulse_rst();
    t_read();
    t_wp();
    t_prot();
    tally_and_finish();
  end
endmodule : ewp_slave_test
